//--- dmag_top.sv
`timescale 1ns/1ps
`include "dmag_map.svh"
module dmag_top
    import dmag_pkg::*;
#(
    parameter logic [15:0] IMPL_BANKS = 16'hFFFF,
    parameter int NUM_PTR = 3
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Core request
    input wire dmag_req_type CORE_REQ,
    // Core result
    output logic RES_VALID,
    output logic [11:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [7:0] MEM_WDATA,
    output logic READ_ZERO,
    output logic SET_ZERO,
    output logic KEEP_FLAGS,
    output logic SFR_HIT,
    output logic [7:0] SFR_RDATA,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    logic [3:0] bank_q, bank_d;
    logic [11:0] ptr_q [NUM_PTR];
    logic [11:0] ptr_d [NUM_PTR];
    logic [11:0] last_q, last_d;
    logic res_valid_d, mem_rd_d, mem_wr_d, read_zero_d, set_zero_d, keep_d;
    logic sfr_hit_d;
    logic [11:0] mem_addr_d;
    logic [7:0] mem_wdata_d, sfr_rdata_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_d, rresp_d;

    // Pointer group number, or NUM_PTR when the address is no pointer group
    function automatic int ptr_group(input logic [11:0] a);
        int g;
        g = NUM_PTR;
        for (int i = 0; i < NUM_PTR; i++)
        begin
            if (a[11:4] == (`DMAG_PTR_BASE_HI + 8'(i)))
            begin
                g = i;
            end
        end
        return g;
    endfunction

    function automatic logic is_port(input logic [11:0] a);
        return (ptr_group(a) < NUM_PTR) && (a[3:0] <= `DMAG_OFS_OFFSET);
    endfunction

    always_comb
    begin
        logic [11:0] raw;
        logic [11:0] eff;
        logic [11:0] sum;
        logic go;
        int g;
        int h;
        raw = 12'h000;
        eff = 12'h000;
        sum = 12'h000;
        go = 1'b0;
        g = NUM_PTR;
        h = NUM_PTR;
        bank_d = bank_q;
        ptr_d = ptr_q;
        last_d = last_q;
        res_valid_d = 1'b0;
        mem_rd_d = 1'b0;
        mem_wr_d = 1'b0;
        mem_addr_d = MEM_ADDR;
        mem_wdata_d = MEM_WDATA;
        read_zero_d = 1'b0;
        set_zero_d = 1'b0;
        keep_d = 1'b0;
        sfr_hit_d = 1'b0;
        sfr_rdata_d = SFR_RDATA;
        // AXI write applied first so a core write in the same cycle wins
        if (aw_have_q && w_have_q && !S_AXI_BVALID)
        begin
            unique case (awaddr_q)
                `DMAG_AXI_BANK:
                begin
                    if (wstrb_q[0])
                    begin
                        bank_d = wdata_q[3:0];
                    end
                end
                `DMAG_AXI_PTR0, `DMAG_AXI_PTR1, `DMAG_AXI_PTR2:
                begin
                    for (int i = 0; i < NUM_PTR; i++)
                    begin
                        if (awaddr_q == (`DMAG_AXI_PTR0 + 8'(4 * i)))
                        begin
                            if (wstrb_q[0])
                            begin
                                ptr_d[i][7:0] = wdata_q[7:0];
                            end
                            if (wstrb_q[1])
                            begin
                                ptr_d[i][11:8] = wdata_q[11:8];
                            end
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (CORE_REQ.valid)
        begin
            res_valid_d = 1'b1;
            go = 1'b1;
            unique case (CORE_REQ.kind)
                DMAG_DIRECT:
                begin
                    if (!CORE_REQ.access_bit)
                    begin
                        // Window below 96 maps to bank 0, the rest to bank 15
                        if (CORE_REQ.operand < `DMAG_LOW_WIN_SIZE)
                        begin
                            raw = {`DMAG_LOW_WIN_BANK, CORE_REQ.operand};
                        end
                        else
                        begin
                            raw = {`DMAG_HIGH_WIN_BANK, CORE_REQ.operand};
                        end
                    end
                    else
                    begin
                        raw = {bank_q, CORE_REQ.operand};
                    end
                end
                DMAG_FULL_MOVE:
                begin
                    raw = CORE_REQ.full_addr;
                end
                DMAG_LOAD_BANK:
                begin
                    bank_d = CORE_REQ.operand[3:0];
                    go = 1'b0;
                end
                default:
                begin
                    go = 1'b0;
                end
            endcase
        end
        if (go)
        begin
            eff = raw;
            g = ptr_group(raw);
            if (is_port(raw))
            begin
                // Stepping is 12-bit modular and reports no flag
                unique case (raw[3:0])
                    `DMAG_OFS_POSTDEC:
                    begin
                        eff = ptr_q[g];
                        ptr_d[g] = ptr_q[g] - 12'h001;
                    end
                    `DMAG_OFS_POSTINC:
                    begin
                        eff = ptr_q[g];
                        ptr_d[g] = ptr_q[g] + 12'h001;
                    end
                    `DMAG_OFS_PREINC:
                    begin
                        sum = ptr_q[g] + 12'h001;
                        eff = sum;
                        ptr_d[g] = sum;
                    end
                    `DMAG_OFS_OFFSET:
                    begin
                        // Sign-extended accumulator; pointer left alone
                        eff = ptr_q[g] + {{4{CORE_REQ.working_accumulator[7]}},
                                          CORE_REQ.working_accumulator};
                    end
                    default:
                    begin
                        eff = ptr_q[g];
                    end
                endcase
            end
            h = ptr_group(eff);
            mem_addr_d = eff;
            mem_wdata_d = CORE_REQ.wdata;
            last_d = eff;
            if (is_port(raw) && is_port(eff))
            begin
                if (CORE_REQ.write)
                begin
                    keep_d = 1'b1;
                end
                else
                begin
                    read_zero_d = 1'b1;
                    set_zero_d = 1'b1;
                end
            end
            else if (eff == `DMAG_BANK_SEL_ADDR)
            begin
                sfr_hit_d = 1'b1;
                sfr_rdata_d = {4'h0, bank_q};
                if (CORE_REQ.write)
                begin
                    bank_d = CORE_REQ.wdata[3:0];
                end
            end
            else if (h < NUM_PTR && eff[3:0] == `DMAG_OFS_LOW)
            begin
                sfr_hit_d = 1'b1;
                sfr_rdata_d = ptr_q[h][7:0];
                if (CORE_REQ.write)
                begin
                    ptr_d[h][7:0] = CORE_REQ.wdata;
                end
            end
            else if (h < NUM_PTR && eff[3:0] == `DMAG_OFS_HIGH)
            begin
                sfr_hit_d = 1'b1;
                sfr_rdata_d = {4'h0, ptr_q[h][11:8]};
                if (CORE_REQ.write)
                begin
                    ptr_d[h][11:8] = CORE_REQ.wdata[3:0];
                end
            end
            else if (!IMPL_BANKS[eff[11:8]])
            begin
                // Bank index is the top nibble of sixteen 256-byte banks
                read_zero_d = !CORE_REQ.write;
            end
            else
            begin
                mem_rd_d = !CORE_REQ.write;
                mem_wr_d = CORE_REQ.write;
            end
        end
    end

    // AXI4-Lite slave handshakes
    always_comb
    begin
        logic wr_go;
        wr_go = aw_have_q && w_have_q && !S_AXI_BVALID;
        awready_d = S_AXI_AWVALID && !S_AXI_AWREADY && !aw_have_q && !S_AXI_BVALID;
        wready_d = S_AXI_WVALID && !S_AXI_WREADY && !w_have_q && !S_AXI_BVALID;
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = S_AXI_BVALID;
        bresp_d = S_AXI_BRESP;
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_have_d = 1'b1;
            awaddr_d = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_have_d = 1'b1;
            wdata_d = S_AXI_WDATA;
            wstrb_d = S_AXI_WSTRB;
        end
        if (wr_go)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            if (awaddr_q == `DMAG_AXI_BANK || awaddr_q == `DMAG_AXI_PTR0 ||
                awaddr_q == `DMAG_AXI_PTR1 || awaddr_q == `DMAG_AXI_PTR2)
            begin
                bresp_d = `DMAG_RESP_OKAY;
            end
            else
            begin
                bresp_d = `DMAG_RESP_SLVERR;
            end
        end
        else if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            bvalid_d = 1'b0;
        end
        arready_d = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
        rvalid_d = S_AXI_RVALID;
        rdata_d = S_AXI_RDATA;
        rresp_d = S_AXI_RRESP;
        if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            rvalid_d = 1'b1;
            rresp_d = `DMAG_RESP_OKAY;
            unique case (S_AXI_ARADDR)
                `DMAG_AXI_BANK: rdata_d = {28'h000_0000, bank_q};
                `DMAG_AXI_PTR0: rdata_d = {20'h0_0000, ptr_q[0]};
                `DMAG_AXI_PTR1: rdata_d = {20'h0_0000, ptr_q[1]};
                `DMAG_AXI_PTR2: rdata_d = {20'h0_0000, ptr_q[2]};
                `DMAG_AXI_LAST: rdata_d = {20'h0_0000, last_q};
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `DMAG_RESP_SLVERR;
                end
            endcase
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            bank_q <= `DMAG_BANK_RESET;
            for (int i = 0; i < NUM_PTR; i++)
            begin
                ptr_q[i] <= `DMAG_PTR_RESET;
            end
            last_q <= 12'h000;
            RES_VALID <= 1'b0;
            MEM_ADDR <= 12'h000;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            MEM_WDATA <= 8'h00;
            READ_ZERO <= 1'b0;
            SET_ZERO <= 1'b0;
            KEEP_FLAGS <= 1'b0;
            SFR_HIT <= 1'b0;
            SFR_RDATA <= 8'h00;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `DMAG_RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `DMAG_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            bank_q <= bank_d;
            ptr_q <= ptr_d;
            last_q <= last_d;
            RES_VALID <= res_valid_d;
            MEM_ADDR <= mem_addr_d;
            MEM_RD <= mem_rd_d;
            MEM_WR <= mem_wr_d;
            MEM_WDATA <= mem_wdata_d;
            READ_ZERO <= read_zero_d;
            SET_ZERO <= set_zero_d;
            KEEP_FLAGS <= keep_d;
            SFR_HIT <= sfr_hit_d;
            SFR_RDATA <= sfr_rdata_d;
            S_AXI_AWREADY <= awready_d;
            S_AXI_WREADY <= wready_d;
            S_AXI_BVALID <= bvalid_d;
            S_AXI_BRESP <= bresp_d;
            S_AXI_ARREADY <= arready_d;
            S_AXI_RVALID <= rvalid_d;
            S_AXI_RDATA <= rdata_d;
            S_AXI_RRESP <= rresp_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
        end
    end
endmodule

//--- dmag_map.svh
// Functional notes
// - Access window is bank 15's top 160 bytes plus bank 0's bottom 96 bytes.
// - Instruction access bit picks bank select register or the fixed access window.
// - With access bit zero, the low window's last byte leads into the high window.
// - Bank select low four bits form the upper four bits of direct addresses.
// - Bank select upper four bits read zero; writes to them do nothing.
// - Unimplemented bank reads zero, ignores writes, flags still update normally.
// - Data memory is sixteen banks of 256 bytes each.
// - Memory-to-memory move uses its full 12-bit addresses, ignoring bank select.
// - Three 12-bit pointers, each held as a high and a low register.
// - A dereference port access goes to the location its pointer holds.
// - Pointer aimed at a port: read gives 00h and zero flag; write is a no-op.
// - Five addresses per pointer: plain, post-dec, post-inc, pre-inc, signed offset.
// - Offset mode adds signed accumulator to pointer; neither one is modified.
// - Automatic pointer stepping never touches any status flag.
// - Pointer stepping spans all 12 bits, carrying between low and high parts.
// - A write to a pointer's own register beats its automatic step; a high-register write still steps the low byte, and a step beats AXI writes.
`ifndef DMAG_MAP_SVH
`define DMAG_MAP_SVH
// Core-side locations of the block's own registers
`define DMAG_BANK_SEL_ADDR 12'hFB0
`define DMAG_PTR_BASE_HI 8'hF8
`define DMAG_OFS_PLAIN 4'h0
`define DMAG_OFS_POSTDEC 4'h1
`define DMAG_OFS_POSTINC 4'h2
`define DMAG_OFS_PREINC 4'h3
`define DMAG_OFS_OFFSET 4'h4
`define DMAG_OFS_LOW 4'h5
`define DMAG_OFS_HIGH 4'h6
// Access window
`define DMAG_LOW_WIN_SIZE 8'h60
`define DMAG_LOW_WIN_BANK 4'h0
`define DMAG_HIGH_WIN_BANK 4'hF
// AXI register offsets
`define DMAG_AXI_BANK 8'h00
`define DMAG_AXI_PTR0 8'h04
`define DMAG_AXI_PTR1 8'h08
`define DMAG_AXI_PTR2 8'h0C
`define DMAG_AXI_LAST 8'h10
// Reset values and responses
`define DMAG_BANK_RESET 4'h0
`define DMAG_PTR_RESET 12'h000
`define DMAG_RESP_OKAY 2'b00
`define DMAG_RESP_SLVERR 2'b10
`endif

//--- dmag_pkg.sv
package dmag_pkg;
    typedef enum logic [1:0] {DMAG_DIRECT, DMAG_FULL_MOVE, DMAG_LOAD_BANK} dmag_kind_type;
    typedef struct packed {
        logic valid;
        dmag_kind_type kind;
        logic write;
        logic access_bit;
        logic [7:0] operand;
        logic [11:0] full_addr;
        logic [7:0] wdata;
        logic [7:0] working_accumulator;
    } dmag_req_type;
endpackage

//--- dmag_sva.sv
`timescale 1ns/1ps
module dmag_sva
    import dmag_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET,
    // Core side
    input wire dmag_req_type CORE_REQ,
    input wire logic RES_VALID,
    input wire logic [11:0] MEM_ADDR,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic READ_ZERO,
    input wire logic SET_ZERO,
    input wire logic KEEP_FLAGS,
    // Bus side
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    // Direct request on a plain operand
    sequence low_s;
        CORE_REQ.valid && CORE_REQ.kind == DMAG_DIRECT && CORE_REQ.operand < 8'h80;
    endsequence
    sequence move_s;
        CORE_REQ.valid && CORE_REQ.kind == DMAG_FULL_MOVE && CORE_REQ.full_addr < 12'hF80;
    endsequence
    sequence ar_s;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    res_pulse_a: assert property (CORE_REQ.valid |=> RES_VALID)
        else $error("result missing");
    res_only_a: assert property (!CORE_REQ.valid |=> !RES_VALID)
        else $error("stray result");
    low_byte_a: assert property (low_s |=> MEM_ADDR[7:0] == $past(CORE_REQ.operand))
        else $error("operand byte lost");
    win_bank_a: assert property (low_s and !CORE_REQ.access_bit |=>
        MEM_ADDR[11:8] == ($past(CORE_REQ.operand) < 8'h60 ? 4'h0 : 4'hF))
        else $error("window bank wrong");
    move_addr_a: assert property (move_s |=> MEM_ADDR == $past(CORE_REQ.full_addr))
        else $error("move address wrong");
    zero_pair_a: assert property (SET_ZERO |-> READ_ZERO && RES_VALID)
        else $error("zero flag without zero read");
    keep_nop_a: assert property (KEEP_FLAGS |-> !MEM_WR && RES_VALID)
        else $error("no-op wrote memory");
    strobe_ok_a: assert property (MEM_RD || MEM_WR |-> RES_VALID && !READ_ZERO)
        else $error("strobe outside result");
    b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    r_answer_a: assert property (ar_s |-> ##[1:2] S_AXI_RVALID)
        else $error("read answer late");
endmodule
bind dmag_top dmag_sva u_sva (.CLK_SYS(CLK_SYS), .RESET(RESET), .CORE_REQ(CORE_REQ),
    .RES_VALID(RES_VALID), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
    .READ_ZERO(READ_ZERO), .SET_ZERO(SET_ZERO), .KEEP_FLAGS(KEEP_FLAGS),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY));

//--- dmag_core_model.sv
`timescale 1ns/1ps
module dmag_core_model
    import dmag_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request to the block
    output dmag_req_type req
);
    initial req = '0;
    // Presents one request for exactly one taking edge
    task automatic issue(input dmag_req_type r);
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req.valid <= 1'b0;
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
`include "dmag_map.svh"
module tb_top;
    import dmag_pkg::*;
    logic clk = 0;
    logic rst = 1;
    dmag_req_type req;
    logic res_valid, mem_rd, mem_wr, read_zero, set_zero, keep_flags, sfr_hit;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata, sfr_rdata;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, resp;
    int err_total = 0, check_count = 0;
    int mptr [3];
    int i, b, op, a, wr, e, z;
    always #25 clk = ~clk;
    dmag_core_model u_core (.clk(clk), .req(req));
    dmag_top #(.IMPL_BANKS(16'hBFFF), .NUM_PTR(3)) u_dut (.CLK_SYS(clk), .RESET(rst),
        .CORE_REQ(req), .RES_VALID(res_valid), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
        .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .READ_ZERO(read_zero), .SET_ZERO(set_zero),
        .KEEP_FLAGS(keep_flags), .SFR_HIT(sfr_hit), .SFR_RDATA(sfr_rdata),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(bready && bvalid))
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if ((!awvalid || awready) && (!wvalid || wready)) bready <= 1'b1;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        while (!(rready && rvalid))
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (arready) rready <= 1'b1;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic go(input dmag_kind_type k, input int w, input int ab, input int o,
        input int fa, input int wd, input int acc);
        dmag_req_type r;
        r = '{1'b1, k, w[0], ab[0], o[7:0], fa[11:0], wd[7:0], acc[7:0]};
        u_core.issue(r);
        #1;
        chk(res_valid, 1);
    endtask
    // Pointer access through one of its five ports, checked against the model
    task automatic ind(input int n, input int m, input int w, input int acc);
        int p;
        p = mptr[n];
        if (m == 3) p = (p + 1) & 'hFFF;
        if (m == 3) mptr[n] = p;
        if (m == 2) mptr[n] = (p + 1) & 'hFFF;
        if (m == 1) mptr[n] = (p - 1) & 'hFFF;
        if (m == 4) p = (p + int'($signed(acc[7:0]))) & 'hFFF;
        go(DMAG_DIRECT, w, 0, 'h80 + 16 * n + m, 0, 'h3C, acc);
        chk(mem_addr, p);
        chk({set_zero, keep_flags}, 0);
        chk(mem_wdata, 'h3C);
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #(50 * 6000);
        err_total++;
        test_done;
    end
    initial
    begin
        i = $urandom(32'hf322);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        axi_rd(`DMAG_AXI_BANK, rd, resp);
        chk(rd, 0);
        axi_wr(`DMAG_AXI_BANK, 32'h0000_00FF, resp);
        axi_rd(`DMAG_AXI_BANK, rd, resp);
        chk(rd, 'h0F);
        axi_rd(8'h14, rd, resp);
        chk(resp, `DMAG_RESP_SLVERR);
        chk(rd, 0);
        axi_wr(`DMAG_AXI_LAST, 32'h0000_0123, resp);
        chk(resp, `DMAG_RESP_SLVERR);
        for (i = 0; i < 24; i++)
        begin
            b = $urandom % 15;
            op = $urandom % 128;
            a = $urandom % 2;
            wr = $urandom % 2;
            axi_wr(`DMAG_AXI_BANK, b, resp);
            go(DMAG_DIRECT, wr, a, op, 0, 'h5A, 0);
            e = a ? b * 256 + op : (op < 'h60 ? op : 'hF00 + op);
            z = a && b == 14;
            chk(mem_addr, e);
            chk({mem_rd, mem_wr, read_zero}, {!wr && !z, wr && !z, !wr && z});
        end
        for (i = 0; i < 8; i++)
        begin
            e = $urandom % 'hF80;
            go(DMAG_FULL_MOVE, i % 2, 1, 'hFF, e, i, 0);
            chk(mem_addr, e);
        end
        axi_wr(`DMAG_AXI_PTR0, 'h0FF, resp);
        axi_wr(`DMAG_AXI_PTR1, 0, resp);
        axi_wr(`DMAG_AXI_PTR2, 'hFFF, resp);
        mptr = '{'h0FF, 0, 'hFFF};
        ind(0, 2, 0, 0);
        ind(0, 0, 1, 0);
        ind(1, 1, 0, 0);
        ind(1, 0, 1, 0);
        ind(2, 3, 0, 0);
        ind(0, 4, 0, 'hFE);
        ind(0, 4, 1, 'h05);
        ind(0, 0, 0, 0);
        axi_wr(`DMAG_AXI_PTR1, 'hF80, resp);
        go(DMAG_DIRECT, 0, 0, 'h90, 0, 0, 0);
        chk({read_zero, set_zero, keep_flags}, 3'b110);
        go(DMAG_DIRECT, 1, 0, 'h90, 0, 0, 0);
        chk({mem_wr, set_zero, keep_flags}, 3'b001);
        axi_wr(`DMAG_AXI_PTR2, 'hFA5, resp);
        go(DMAG_DIRECT, 1, 0, 'hA2, 0, 'h33, 0);
        axi_rd(`DMAG_AXI_PTR2, rd, resp);
        chk(rd, 'hF33);
        go(DMAG_DIRECT, 0, 0, 'hA6, 0, 0, 0);
        chk({sfr_hit, sfr_rdata}, 'h10F);
        go(DMAG_DIRECT, 0, 0, 'hA5, 0, 0, 0);
        chk({sfr_hit, sfr_rdata}, 'h133);
        go(DMAG_LOAD_BANK, 0, 0, 'hA7, 0, 'hA7, 0);
        axi_rd(`DMAG_AXI_BANK, rd, resp);
        chk(rd, 7);
        go(DMAG_DIRECT, 0, 0, 'hB0, 0, 0, 0);
        chk({sfr_hit, sfr_rdata}, 'h107);
        go(DMAG_DIRECT, 1, 0, 'hB0, 0, 'hC9, 0);
        chk(sfr_hit, 1);
        axi_rd(`DMAG_AXI_BANK, rd, resp);
        chk(rd, 9);
        test_done;
    end
endmodule
